// >>> fdps_phase_seq.sv
// Overview of operation
// - Every operation runs command phase, then execution, then any results.
// - The first command byte is the opcode, later bytes are parameters.
// - Execution starts at once when the last command byte is taken.
// - Execution is a drive data transfer, a mechanical action or internal.
// - Drive data moves by DMA channel 2 with request and low acknowledge.
// - Results are status bytes read one by one from the data port.
// - Commands without results go straight back to accepting commands.
// - With no command in progress the controller sits idle.
// - Main status shows ready, direction, non-DMA execution and busy.
`include "fdps_defs.svh"
module fdps_phase_seq
    import fdps_pkg::*;
#(
    parameter int XFER_BYTES = 4,
    parameter logic [7:0] RESULT_BASE = 8'h20
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [9:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic dma_ch2_request,
    input wire logic dma_ch2_acknowledge_n,
    input wire logic [7:0] dma_rdata,
    output logic [7:0] dma_wdata,
    output logic drive_step,
    output logic [7:0] drive_wdata,
    output logic drive_wvalid,
    input wire logic drive_wready
);
    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    function automatic fdps_cmd_s decode(input logic [4:0] op);
        fdps_cmd_s c;
        c = '{params: 4'd0, results: 4'd0, kind: EX_INTERNAL};
        unique case (op)
            `FDPS_OP_READ: c = '{4'd8, 4'd7, EX_DMA_RD};
            `FDPS_OP_WRITE: c = '{4'd8, 4'd7, EX_DMA_WR};
            `FDPS_OP_SEEK: c = '{4'd2, 4'd0, EX_MECH};
            `FDPS_OP_RECAL: c = '{4'd1, 4'd0, EX_MECH};
            `FDPS_OP_SPECIFY: c = '{4'd2, 4'd0, EX_INTERNAL};
            `FDPS_OP_SENSE_INT: c = '{4'd0, 4'd2, EX_INTERNAL};
            default: c = '{4'd0, 4'd1, EX_INTERNAL};
        endcase
        return c;
    endfunction : decode

    function automatic logic is_addr(input logic [9:0] a, input logic [9:0] p,
        input logic [9:0] s);
        return a == p || a == s;
    endfunction : is_addr

    // ----------------------------------------
    // Sampled host pins
    // ----------------------------------------
    fdps_hreq_s h_s1;
    fdps_hreq_s h_s2;
    fdps_hreq_s h_s3;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            h_s1 <= '0;
            h_s2 <= '0;
            h_s3 <= '0;
        end
        else
        begin
            h_s1 <= '{host_rd, host_wr, host_addr, host_wdata};
            h_s2 <= h_s1;
            h_s3 <= h_s2;
        end
    end
    logic ack_s1;
    logic ack_n;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_s1 <= 1'b1;
            ack_n <= 1'b1;
        end
        else
        begin
            ack_s1 <= dma_ch2_acknowledge_n;
            ack_n <= ack_s1;
        end
    end

    // ----------------------------------------
    // Phase state
    // ----------------------------------------
    fdps_phase_e phase;
    fdps_phase_e next_phase;
    fdps_cmd_s cmd;
    logic [4:0] opcode;
    logic [3:0] left;
    logic [7:0] work;
    logic [7:0] msr;
    logic [7:0] rdata;
    logic ack_d;

    wire logic rd_edge = h_s2.rd && !h_s3.rd;
    wire logic wr_edge = h_s2.wr && !h_s3.wr;
    wire logic at_data = is_addr(h_s2.addr, `FDPS_ADDR_DATA_PORT,
        `FDPS_ADDR_DATA_PORT_SEC);
    wire logic at_msr = is_addr(h_s2.addr, `FDPS_ADDR_MAIN_STATUS,
        `FDPS_ADDR_MAIN_STATUS_SEC);
    wire logic rqm = phase == PH_IDLE || phase == PH_CMD
        || phase == PH_RESULT;
    wire logic dio = phase == PH_RESULT;
    // Wrong-direction accesses fall out here and change nothing
    wire logic take_wr = wr_edge && at_data && rqm && !dio;
    wire logic take_rd = rd_edge && at_data && rqm && dio;
    wire fdps_cmd_s dec = decode(h_s2.wdata[4:0]);
    wire logic dma_kind = cmd.kind == EX_DMA_RD || cmd.kind == EX_DMA_WR;
    wire logic ack_fall = !ack_n && ack_d;
    wire logic exec_done = phase == PH_EXEC && left == 4'd0 && work == 8'd0;
    wire logic buf_ready;

    always_comb
    begin
        next_phase = phase;
        unique case (phase)
            PH_IDLE:
                if (take_wr)
                    next_phase = dec.params == 4'd0 ? PH_EXEC : PH_CMD;
            PH_CMD:
                if (take_wr && left == 4'd1)
                    next_phase = PH_EXEC;
            PH_EXEC:
                if (exec_done)
                    next_phase = cmd.results == 4'd0 ? PH_IDLE : PH_RESULT;
            PH_RESULT:
                if (take_rd && left == 4'd1)
                    next_phase = PH_IDLE;
        endcase
    end

    // Bit 5 only while a non-DMA execution is running
    assign msr = {rqm, dio, phase == PH_EXEC && !dma_kind,
        phase != PH_IDLE, 4'h0};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            phase <= PH_IDLE;
        else
            phase <= next_phase;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd <= '{4'd0, 4'd0, EX_INTERNAL};
            opcode <= 5'h00;
            left <= 4'd0;
            work <= 8'd0;
            ack_d <= 1'b1;
        end
        else
        begin
            ack_d <= ack_n;
            if (phase == PH_IDLE && take_wr)
            begin
                cmd <= dec;
                opcode <= h_s2.wdata[4:0];
                left <= dec.params;
                work <= dec.kind == EX_MECH ? 8'(`FDPS_MECH_CYC)
                    : dec.kind == EX_INTERNAL ? 8'd1 : 8'(XFER_BYTES);
            end
            else if (phase == PH_CMD && take_wr)
                left <= left - 4'd1;
            else if (phase == PH_EXEC)
            begin
                if (work != 8'd0 && (!dma_kind || ack_fall))
                    work <= work - 8'd1;
                if (exec_done)
                    left <= cmd.results;
            end
            else if (phase == PH_RESULT && take_rd)
                left <= left - 4'd1;
        end
    end

    // ----------------------------------------
    // Host read data
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata <= 8'h00;
        else if (rd_edge && at_msr)
            rdata <= msr;
        else if (take_rd)
            rdata <= RESULT_BASE + 8'({opcode[3:0], left});
    end
    assign host_rdata = rdata;

    // ----------------------------------------
    // DMA and drive side
    // ----------------------------------------
    // On DMA writes, request drops while the buffer toward the drive is full
    assign dma_ch2_request = phase == PH_EXEC && dma_kind && work != 8'd0
        && ack_n && (cmd.kind == EX_DMA_RD || buf_ready);
    assign drive_step = phase == PH_EXEC && cmd.kind == EX_MECH
        && work == 8'd1;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dma_wdata <= 8'h00;
        else if (phase == PH_EXEC && cmd.kind == EX_DMA_RD && ack_fall)
            dma_wdata <= {4'h0, work[3:0]};
    end

    fdps_skid_buf #(.WIDTH(8)) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(phase == PH_EXEC && cmd.kind == EX_DMA_WR && ack_fall),
        .in_ready(buf_ready),
        .in_data(dma_rdata),
        .out_valid(drive_wvalid),
        .out_ready(drive_wready),
        .out_data(drive_wdata)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_phase_order: assert property (@(posedge clk) disable iff (sys_rst)
        phase == PH_RESULT && $past(phase) != PH_RESULT
        |-> $past(phase) == PH_EXEC)
        else $error("results entered not from execution");
    a_opcode_first: assert property (@(posedge clk) disable iff (sys_rst)
        phase == PH_IDLE && take_wr |=> left == $past(dec.params))
        else $error("opcode did not set parameter count");
    a_exec_at_once: assert property (@(posedge clk) disable iff (sys_rst)
        phase == PH_CMD && take_wr && left == 4'd1 |=> phase == PH_EXEC)
        else $error("execution did not start at once");
    a_dma_only_exec: assert property (@(posedge clk) disable iff (sys_rst)
        dma_ch2_request |-> phase == PH_EXEC && dma_kind)
        else $error("dma request outside dma execution");
    a_no_result_skip: assert property (@(posedge clk) disable iff (sys_rst)
        exec_done && cmd.results == 4'd0 |=> phase == PH_IDLE)
        else $error("result phase not skipped");
    a_result_count: assert property (@(posedge clk) disable iff (sys_rst)
        phase == PH_RESULT && take_rd && left == 4'd1 |=> phase == PH_IDLE)
        else $error("result phase did not end");
    a_msr_busy: assert property (@(posedge clk) disable iff (sys_rst)
        take_wr |=> msr[`FDPS_MSR_BUSY] && !msr[`FDPS_MSR_DIO])
        else $error("main status bits wrong");
    a_wrong_dir: assert property (@(posedge clk) disable iff (sys_rst)
        phase == PH_RESULT && wr_edge && at_data |=> phase == PH_RESULT)
        else $error("wrong-direction write changed phase");
    a_idle_stays: assert property (@(posedge clk) disable iff (sys_rst)
        phase == PH_IDLE && !take_wr |=> phase == PH_IDLE)
        else $error("left idle without command");
    c_dma_read: cover property (@(posedge clk) disable iff (sys_rst)
        phase == PH_EXEC && cmd.kind == EX_DMA_RD ##1 phase == PH_RESULT);
    c_seek: cover property (@(posedge clk) disable iff (sys_rst)
        phase == PH_EXEC && cmd.kind == EX_MECH ##1 phase == PH_IDLE);
    c_full_buf: cover property (@(posedge clk) disable iff (sys_rst)
        !buf_ready && phase == PH_EXEC);
endmodule : fdps_phase_seq

// >>> fdps_defs.svh
`ifndef FDPS_DEFS_SVH
`define FDPS_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define FDPS_ADDR_MAIN_STATUS 10'h3f4
`define FDPS_ADDR_DATA_PORT 10'h3f5
`define FDPS_ADDR_MAIN_STATUS_SEC 10'h374
`define FDPS_ADDR_DATA_PORT_SEC 10'h375
// ----------------------------------------
// Main status fields
// ----------------------------------------
`define FDPS_MSR_RQM 7
`define FDPS_MSR_DIO 6
`define FDPS_MSR_NDMA 5
`define FDPS_MSR_BUSY 4
// ----------------------------------------
// Opcodes and timing
// ----------------------------------------
`define FDPS_OP_READ 5'h06
`define FDPS_OP_WRITE 5'h05
`define FDPS_OP_SEEK 5'h0f
`define FDPS_OP_SENSE_INT 5'h08
`define FDPS_OP_SPECIFY 5'h03
`define FDPS_OP_RECAL 5'h07
`define FDPS_MECH_NS 100
`define FDPS_CLK_NS 5
`define FDPS_MECH_CYC ((`FDPS_MECH_NS + `FDPS_CLK_NS - 1) / `FDPS_CLK_NS)
`endif

// >>> fdps_pkg.sv
package fdps_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CMD,
        PH_EXEC,
        PH_RESULT
    } fdps_phase_e;
    typedef enum logic [1:0] {
        EX_DMA_RD,
        EX_DMA_WR,
        EX_MECH,
        EX_INTERNAL
    } fdps_exec_e;
    typedef struct packed {
        logic [3:0] params;
        logic [3:0] results;
        fdps_exec_e kind;
    } fdps_cmd_s;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } fdps_hreq_s;
endpackage : fdps_pkg

// >>> fdps_skid_buf.sv
module fdps_skid_buf
    import fdps_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // ----------------------------------------
    // Two-entry buffer
    // ----------------------------------------
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;

    assign in_ready = count != 2'd2;
    assign out_valid = count != 2'd0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            count <= count + 2'(push) - 2'(pop);
        end
    end

    a_buf_no_overflow: assert property (@(posedge clk) disable iff (sys_rst)
        in_valid |-> in_ready)
        else $error("word offered while buffer full");
endmodule : fdps_skid_buf

// >>> fdps_dma_partner.sv
module fdps_dma_partner
    import fdps_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    input wire logic dma_ch2_request,
    output logic dma_ch2_acknowledge_n,
    output logic [7:0] dma_rdata,
    input wire logic drive_wvalid,
    input wire logic [7:0] drive_wdata,
    output logic drive_wready
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_ack = 0;
    logic [7:0] b;
    logic [7:0] sent_q[$];
    logic [7:0] got_q[$];
    // Ack low 3 clocks, high 3 clocks: the design syncs ack with 2 FFs
    initial
    begin
        dma_ch2_acknowledge_n = 1'b1;
        dma_rdata = 8'h5a;
        forever
        begin
            @(posedge clk);
            if (dma_ch2_request)
            begin
                repeat ($urandom_range(4, 1)) @(posedge clk);
                if (dma_ch2_request)
                begin
                    b = 8'($urandom);
                    sent_q.push_back(b);
                    dma_ch2_acknowledge_n <= 1'b0;
                    dma_rdata <= b;
                    repeat (3) @(posedge clk);
                    dma_ch2_acknowledge_n <= 1'b1;
                    // Released bus shows a changed value, never the old one
                    dma_rdata <= ~b;
                    n_ack++;
                    repeat (3) @(posedge clk);
                end
            end
        end
    end
    initial drive_wready = 1'b0;
    // Captured half a cycle early: valid, ready and data move only on posedge
    always @(negedge clk)
    begin
        if (drive_wvalid && drive_wready)
            got_q.push_back(drive_wdata);
    end
    always @(posedge clk)
        drive_wready <= !stall && ($urandom_range(3, 0) != 0);
endmodule : fdps_dma_partner

// >>> fdps_phase_seq_tb.sv
`include "fdps_defs.svh"
module fdps_phase_seq_tb
    import fdps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int XB = 4;
    logic clk, sys_rst, host_rd, host_wr, stall, sec;
    logic [9:0] host_addr;
    logic [7:0] host_wdata, host_rdata, dma_wdata, drive_wdata;
    logic req, ack_n, drive_step, drive_wvalid, drive_wready;
    logic [7:0] dma_rdata;
    int n_fail = 0, compares = 0, cycles = 0, n_step = 0;
    fdps_phase_seq #(.XFER_BYTES(XB), .RESULT_BASE(8'h20)) dut (
        .clk(clk), .sys_rst(sys_rst), .host_rd(host_rd),
        .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .dma_ch2_request(req), .dma_ch2_acknowledge_n(ack_n),
        .dma_rdata(dma_rdata), .dma_wdata(dma_wdata),
        .drive_step(drive_step), .drive_wdata(drive_wdata),
        .drive_wvalid(drive_wvalid), .drive_wready(drive_wready));
    fdps_dma_partner u_far (
        .clk(clk), .stall(stall), .dma_ch2_request(req),
        .dma_ch2_acknowledge_n(ack_n), .dma_rdata(dma_rdata),
        .drive_wvalid(drive_wvalid), .drive_wdata(drive_wdata),
        .drive_wready(drive_wready));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // Pulse counted mid-cycle so the edge that launches it cannot race it
    always @(negedge clk)
        if (drive_step === 1'b1)
            n_step++;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // -----------------------------------
    // Host bus: strobe held 4 clocks, data valid 3 clocks after rise
    // -----------------------------------
    task automatic bus(logic rd, logic dat, logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        host_rd <= rd;
        host_wr <= !rd;
        host_addr <= (sec ? 10'h374 : 10'h3f4) + {9'h0, dat};
        host_wdata <= d;
        repeat (4) @(posedge clk);
        q = host_rdata;
        host_rd <= 1'b0;
        host_wr <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : bus
    task automatic msr(logic [3:0] exp);
        logic [7:0] q;
        bus(1'b1, 1'b0, 8'h00, q);
        check("main_status", {q[7:4], 4'h0}, {exp, 4'h0});
    endtask : msr
    function automatic int n_par(logic [4:0] op);
        case (op)
            5'h06, 5'h05: return 8;
            5'h0f, 5'h03: return 2;
            5'h07: return 1;
            default: return 0;
        endcase
    endfunction : n_par
    function automatic int n_res(logic [4:0] op);
        case (op)
            5'h06, 5'h05: return 7;
            5'h08: return 2;
            5'h0f, 5'h07, 5'h03: return 0;
            default: return 1;
        endcase
    endfunction : n_res
    task automatic run_cmd(logic [7:0] op);
        logic [7:0] q;
        int k, s0, a0, nr;
        logic dma, mech;
        dma = (op[4:0] == 5'h06) || (op[4:0] == 5'h05);
        mech = (op[4:0] == 5'h0f) || (op[4:0] == 5'h07);
        s0 = n_step;
        a0 = u_far.n_ack;
        nr = n_res(op[4:0]);
        u_far.sent_q.delete();
        u_far.got_q.delete();
        stall <= (op[4:0] == 5'h05);
        msr(4'h8);
        bus(1'b0, 1'b1, op, q);
        for (k = 0; k < n_par(op[4:0]); k++)
        begin
            msr(4'h9);
            bus(1'b0, 1'b1, 8'($urandom), q);
        end
        if (dma || mech)
            msr(dma ? 4'h1 : 4'h3);
        k = 0;
        do
        begin
            bus(1'b1, 1'b0, 8'h00, q);
            k++;
            if (k == 12 && stall)
            begin
                check("buf_full_valid", {7'h0, drive_wvalid}, 8'h01);
                stall <= 1'b0;
            end
        end
        while (q[7] !== 1'b1 && k < 300);
        check("main_status", {q[7:4], 4'h0}, nr ? 8'hd0 : 8'h80);
        if (nr > 0)
            bus(1'b0, 1'b1, 8'hff, q);
        for (k = 0; k < nr; k++)
        begin
            bus(1'b1, 1'b1, 8'h00, q);
            check("result", q, 8'h20 + {op[3:0], 4'(nr - k)});
        end
        msr(4'h8);
        check("acks", 8'(u_far.n_ack - a0), dma ? 8'(XB) : 8'h0);
        if (op[4:0] == 5'h06)
            check("dma_byte", dma_wdata, 8'h01);
        check("steps", 8'(n_step - s0), mech ? 8'h1 : 8'h0);
        if (op[4:0] == 5'h05)
            for (k = 0; k < XB; k++)
                check("drive_word", u_far.got_q[k], u_far.sent_q[k]);
    endtask : run_cmd
    initial
    begin
        logic [7:0] q;
        logic [7:0] ops[6] = '{8'h06, 8'h05, 8'h0f, 8'h07, 8'h03, 8'h08};
        sys_rst = 1'b1;
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_addr = 10'h3f4;
        host_wdata = 8'h00;
        stall = 1'b0;
        sec = 1'b0;
        void'($urandom(32'h145f));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b1, 1'b1, 8'h00, q);
        check("ignored_read", q, 8'h00);
        msr(4'h8);
        foreach (ops[i])
        begin
            sec = 1'($urandom);
            run_cmd(ops[i]);
        end
        repeat (3)
            run_cmd({3'($urandom), 1'b1, 4'($urandom)});
        bus(1'b0, 1'b1, 8'h06, q);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        msr(4'h8);
        run_cmd(8'he6);
        print_verdict();
    end
endmodule : fdps_phase_seq_tb
